/* File: rtl/add_unit.sv */
`timescale 1ns/1ps

// Contract
// - Destination receives second operand plus first operand for every add; the write is skipped on unmasked integer overflow, invalid or reserved fault.
// - Signed overflow means like-signed sources giving a result of other sign.
// - Long real operands name the lower register of a consecutive pair.
// - Opposite-sign exact zero sum gives +0, or -0 when rounding down.
// - Zero plus zero of same sign keeps that sign.
// - Plus infinity plus minus infinity signals invalid operation.
// - NaN in gives NaN; infinity dominates; finite plus zero is unchanged.
// - Normalized result too small for the format raises underflow.
// - Any signalling NaN source raises invalid operation; here a denormal other source in normalizing mode raises only reserved fault.
// - Denormal operand with normalizing mode set raises reserved-encoding fault.
// - Inexact result raises inexact, subject to its mask.
module add_unit
  import add_unit_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             irq
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    return a[11:2] == ofs[11:2];
  endfunction

  function automatic fop_t unpack(input logic [63:0] v, input logic lng);
    fop_t        o;
    logic [10:0] e;
    logic [51:0] f;
    logic [10:0] emax;
    e    = lng ? v[62:52] : {3'h0, v[30:23]};
    f    = lng ? v[51:0] : {v[22:0], {S_FRAC_PAD{1'b0}}};
    emax = lng ? D_EMAX : S_EMAX;
    o.sign   = lng ? v[63] : v[31];
    o.zero   = (e == 11'h000) && (f == '0);
    o.denorm = (e == 11'h000) && (f != '0);
    o.inf    = (e == emax) && (f == '0);
    o.nan    = (e == emax) && (f != '0);
    o.snan   = o.nan && !f[51];
    o.exp    = (e == 11'h000) ? 11'h001 : e;
    o.mant   = {1'b0, e != 11'h000, f, {MANT_PAD{1'b0}}};
    return o;
  endfunction

  function automatic logic [5:0] lead_zeros(input logic [62:0] v);
    logic [5:0] n;
    logic       found;
    n     = 6'h00;
    found = 1'b0;
    for (int i = 62; i >= 0; i--) begin
      if (!found) begin
        if (v[i]) found = 1'b1;
        else n = n + 6'h01;
      end
    end
    return n;
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic [31:0]     regs_q [NREGS];
  logic [31:0]     cmd_q;
  logic [31:0]     actl_q;
  logic [EV_W-1:0] ist_q;
  logic [EV_W-1:0] ien_q;
  logic [EV_W-1:0] last_ev_q;
  exec_state_t     state_q;
  logic            wr_pend_q;
  logic [11:0]     wr_addr_q;
  logic            rd_pend_q;
  logic [11:0]     rd_addr_q;

  logic            addr_ok;
  logic            bus_wr;
  logic            exec;
  add_op_t         op;
  logic            lng;
  logic [IDX_W-1:0] i1, i2, id;
  logic [63:0]     v1, v2;
  logic [63:0]     res;
  logic            wr_en;
  logic [EV_W-1:0] ev;

  assign addr_ok = hsel && htrans[1] && hready;
  assign bus_wr  = wr_pend_q;
  assign exec    = (state_q == ST_EXEC);
  assign op      = add_op_t'(cmd_q[1:0]);
  assign lng     = (op == OP_ADDRL);

  // ****************************************
  // Operand fetch
  // ****************************************
  always_comb begin
    i1 = cmd_q[CMD_S1_LSB +: IDX_W];
    i2 = cmd_q[CMD_S2_LSB +: IDX_W];
    id = cmd_q[CMD_DST_LSB +: IDX_W];
    // Odd names are not trapped; the pair base is forced even instead
    if (lng) begin
      i1[0] = 1'b0;
      i2[0] = 1'b0;
      id[0] = 1'b0;
    end
    v1 = {32'h0000_0000, regs_q[i1]};
    v2 = {32'h0000_0000, regs_q[i2]};
    if (lng) begin
      v1 = {regs_q[i1 | 5'h01], regs_q[i1]};
      v2 = {regs_q[i2 | 5'h01], regs_q[i2]};
    end else if (op == OP_ADDO || op == OP_ADDI) begin
      if (cmd_q[CMD_LIT1_BIT]) v1 = {59'h0, cmd_q[CMD_S1_LSB +: IDX_W]};
      if (cmd_q[CMD_LIT2_BIT]) v2 = {59'h0, cmd_q[CMD_S2_LSB +: IDX_W]};
    end
  end

  // ****************************************
  // Datapath
  // ****************************************
  fop_t               a, b, x, y;
  logic [10:0]        dexp, emax;
  logic [5:0]         sh;
  logic [63:0]        ys, sum, nm, disc;
  logic [5:0]         lz;
  logic signed [12:0] e13;
  logic [32:0]        isum;
  logic               zsign, rm_down, ovf;

  always_comb begin
    a       = unpack(v1, lng);
    b       = unpack(v2, lng);
    emax    = lng ? D_EMAX : S_EMAX;
    rm_down = actl_q[ACTL_RM_LSB +: 2] == RM_DOWN;
    ev      = '0;
    ev[EV_DONE] = 1'b1;
    wr_en   = 1'b1;
    res     = '0;
    x = a;
    y = b;
    if ({b.exp, b.mant} > {a.exp, a.mant}) begin
      x = b;
      y = a;
    end
    dexp = x.exp - y.exp;
    sh   = (dexp > 11'h03F) ? 6'h3F : dexp[5:0];
    ys   = y.mant >> sh;
    ys[0] = ys[0] | (|(y.mant & ~({64{1'b1}} << sh)));
    sum  = (x.sign == y.sign) ? x.mant + ys : x.mant - ys;
    lz   = lead_zeros(sum[62:0]);
    if (sum[63]) begin
      nm  = {1'b0, sum[63:1]} | {63'h0, sum[0]};
      e13 = $signed({2'b00, x.exp}) + 13'sh0001;
    end else begin
      nm  = sum << lz;
      e13 = $signed({2'b00, x.exp}) - $signed({7'h00, lz});
    end
    disc = nm & (lng ? D_DISC : S_DISC);
    zsign = (a.sign == b.sign) ? a.sign : rm_down;
    isum  = {1'b0, v1[31:0]} + {1'b0, v2[31:0]};
    ovf   = (v1[31] == v2[31]) && (isum[31] != v1[31]);
    case (op)
      OP_ADDO: begin
        res = {32'h0, isum[31:0]};
      end
      OP_ADDI: begin
        res = {32'h0, isum[31:0]};
        if (ovf && !actl_q[ACTL_IOVF_MASK]) begin
          ev[EV_IOVF] = 1'b1;
          wr_en       = 1'b0;
        end
      end
      default: begin
        if (actl_q[ACTL_NORM_MODE] && (a.denorm || b.denorm)) begin
          ev[EV_RSV] = 1'b1;
          wr_en      = 1'b0;
        end else if (a.nan || b.nan) begin
          res = (a.nan ? v1 : v2) | (lng ? QBIT_D : QBIT_S);
          if (a.snan || b.snan) begin
            ev[EV_INV] = 1'b1;
            wr_en      = 1'b0;
          end
        end else if (a.inf && b.inf && (a.sign != b.sign)) begin
          ev[EV_INV] = 1'b1;
          wr_en      = 1'b0;
        end else if (a.inf || b.inf) begin
          res = a.inf ? v1 : v2;
        end else if (a.zero && b.zero) begin
          res = lng ? {zsign, 63'h0} : {32'h0, zsign, 31'h0};
        end else if (a.zero || b.zero) begin
          res = a.zero ? v2 : v1;
        end else if (sum == '0) begin
          res = lng ? {zsign, 63'h0} : {32'h0, zsign, 31'h0};
        end else if (e13 >= $signed({2'b00, emax})) begin
          ev[EV_FOVF] = 1'b1;
          ev[EV_INX]  = !actl_q[ACTL_INX_MASK];
          res = lng ? {x.sign, D_EMAX, 52'h0} : {32'h0, x.sign, S_EMAX[7:0], 23'h0};
        end else if (e13 <= 13'sh0000) begin
          ev[EV_FUNF] = 1'b1;
          ev[EV_INX]  = !actl_q[ACTL_INX_MASK];
          res = lng ? {x.sign, 63'h0} : {32'h0, x.sign, 31'h0};
        end else begin
          ev[EV_INX] = (disc != '0) && !actl_q[ACTL_INX_MASK];
          // Magnitude is truncated; only the inexact report depends on it
          res = lng ? {x.sign, e13[10:0], nm[61:10]}
                    : {32'h0, x.sign, e13[7:0], nm[61:39]};
        end
      end
    endcase
  end

  // ****************************************
  // Bus slave
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      if (addr_ok) wr_addr_q <= haddr[11:0];
    end
  end

  // Reads take one wait state so a write just before is always seen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_pend_q <= 1'b0;
      rd_addr_q <= 12'h000;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
    end else begin
      rd_pend_q <= addr_ok && !hwrite;
      hreadyout <= !(addr_ok && !hwrite);
      if (addr_ok && !hwrite) rd_addr_q <= haddr[11:0];
      if (rd_pend_q) begin
        if (rd_addr_q <= REG_TOP) hrdata <= regs_q[rd_addr_q[6:2]];
        else if (hit(rd_addr_q, CMD_OFS)) hrdata <= cmd_q;
        else if (hit(rd_addr_q, ACTL_OFS)) hrdata <= actl_q;
        else if (hit(rd_addr_q, FLAG_OFS)) hrdata <= {24'h0, last_ev_q, exec};
        else if (hit(rd_addr_q, IST_OFS)) hrdata <= {25'h0, ist_q};
        else if (hit(rd_addr_q, IEN_OFS)) hrdata <= {25'h0, ien_q};
        else hrdata <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hresp <= 1'b0;
    else hresp <= 1'b0;
  end

  // ****************************************
  // Control registers and sequencing
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_q   <= 32'h0000_0000;
      actl_q  <= ACTL_RESET;
      ien_q   <= '0;
      state_q <= ST_IDLE;
    end else begin
      if (bus_wr && hit(wr_addr_q, ACTL_OFS)) actl_q <= hwdata;
      if (bus_wr && hit(wr_addr_q, IEN_OFS)) ien_q <= hwdata[EV_W-1:0];
      case (state_q)
        ST_IDLE: begin
          if (bus_wr && hit(wr_addr_q, CMD_OFS)) begin
            cmd_q   <= hwdata;
            state_q <= ST_EXEC;
          end
        end
        ST_EXEC: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Execution write-back wins over a bus write to the same register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NREGS; i++) regs_q[i] <= 32'h0000_0000;
    end else begin
      if (bus_wr && wr_addr_q <= REG_TOP) regs_q[wr_addr_q[6:2]] <= hwdata;
      if (exec && wr_en) begin
        regs_q[id] <= res[31:0];
        if (lng) regs_q[id | 5'h01] <= res[63:32];
      end
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ist_q     <= '0;
      last_ev_q <= '0;
      irq       <= 1'b0;
    end else begin
      ist_q <= (ist_q & ~((bus_wr && hit(wr_addr_q, ICLR_OFS)) ? hwdata[EV_W-1:0] : '0))
             | (exec ? ev : '0);
      if (exec) last_ev_q <= ev;
      irq <= |(ist_q & ien_q);
    end
  end

endmodule // add_unit

/* File: rtl/add_unit_pkg.sv */
package add_unit_pkg;

  // ****************************************
  // Register map (byte offsets, low 12 address bits)
  // ****************************************
  localparam int unsigned NREGS     = 32;
  localparam int unsigned IDX_W     = 5;
  localparam logic [11:0] REG_TOP   = 12'h07C;
  localparam logic [11:0] CMD_OFS   = 12'h080;
  localparam logic [11:0] ACTL_OFS  = 12'h084;
  localparam logic [11:0] FLAG_OFS  = 12'h088;
  localparam logic [11:0] IST_OFS   = 12'h08C;
  localparam logic [11:0] ICLR_OFS  = 12'h090;
  localparam logic [11:0] IEN_OFS   = 12'h094;

  // ****************************************
  // Command and arithmetic-control fields
  // ****************************************
  localparam int unsigned CMD_LIT1_BIT = 2;
  localparam int unsigned CMD_LIT2_BIT = 3;
  localparam int unsigned CMD_S1_LSB   = 8;
  localparam int unsigned CMD_S2_LSB   = 16;
  localparam int unsigned CMD_DST_LSB  = 24;
  localparam int unsigned ACTL_IOVF_MASK = 0;
  localparam int unsigned ACTL_INX_MASK  = 1;
  localparam int unsigned ACTL_NORM_MODE = 2;
  localparam int unsigned ACTL_RM_LSB    = 4;
  localparam logic [1:0]  RM_DOWN        = 2'h2;
  localparam logic [31:0] ACTL_RESET     = 32'h0000_0000;

  typedef enum logic [1:0] {
    OP_ADDO  = 2'h0,
    OP_ADDI  = 2'h1,
    OP_ADDR  = 2'h2,
    OP_ADDRL = 2'h3
  } add_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } exec_state_t;

  // ****************************************
  // Event bits (interrupt status / enable / clear layout)
  // ****************************************
  localparam int unsigned EV_W     = 7;
  localparam int unsigned EV_DONE  = 0;
  localparam int unsigned EV_IOVF  = 1;
  localparam int unsigned EV_FOVF  = 2;
  localparam int unsigned EV_FUNF  = 3;
  localparam int unsigned EV_INV   = 4;
  localparam int unsigned EV_INX   = 5;
  localparam int unsigned EV_RSV   = 6;

  // ****************************************
  // Real formats
  // ****************************************
  localparam logic [10:0] D_EMAX     = 11'h7FF;
  localparam logic [10:0] S_EMAX     = 11'h0FF;
  localparam int unsigned S_FRAC_PAD = 29;
  localparam int unsigned MANT_PAD   = 10;
  localparam logic [63:0] QBIT_D     = 64'h0008_0000_0000_0000;
  localparam logic [63:0] QBIT_S     = 64'h0000_0000_0040_0000;
  localparam logic [63:0] D_DISC     = 64'h0000_0000_0000_03FF;
  localparam logic [63:0] S_DISC     = 64'h0000_007F_FFFF_FFFF;

  typedef struct packed {
    logic        sign;
    logic [10:0] exp;
    logic [63:0] mant;
    logic        zero;
    logic        denorm;
    logic        inf;
    logic        nan;
    logic        snan;
  } fop_t;

endpackage

/* File: verif/add_unit_sva.sv */
`timescale 1ns/1ps

// ****************************
// Bus and interrupt checks
// ****************************
module add_unit_sva (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        irq
);
  logic rd_acc;
  logic wr_acc;

  assign rd_acc = hsel && htrans[1] && hready && !hwrite;
  assign wr_acc = hsel && htrans[1] && hready && hwrite;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  resp_okay_a: assert property (hresp == 1'b0)
    else $error("error response");
  read_wait_a: assert property (rd_acc |=> !hreadyout ##1 hreadyout)
    else $error("read wait not one cycle");
  write_nowait_a: assert property (wr_acc |=> hreadyout)
    else $error("write stretched");
  wait_cause_a: assert property (!hreadyout |-> $past(rd_acc))
    else $error("wait without read");
  rdata_hold_a: assert property (!$rose(hreadyout) |-> $stable(hrdata))
    else $error("read data moved");
  unmapped_zero_a: assert property (rd_acc && haddr[11:0] > 12'h094 |-> ##2 hrdata == 32'h0)
    else $error("unmapped read not zero");
  // Enable write shows on irq three edges after its address phase, a command four
  irq_rise_a: assert property ($rose(irq) |-> $past(wr_acc, 3) || $past(wr_acc, 4))
    else $error("irq rose unprompted");
  irq_fall_a: assert property ($fell(irq) |-> $past(wr_acc, 3))
    else $error("irq fell unprompted");
endmodule // add_unit_sva

/* File: verif/add_unit_tb.sv */
`timescale 1ns/1ps

module add_unit_tb;
  import add_unit_pkg::*;

  localparam int          LIMIT = 20000;
  localparam logic [31:0] KEEP  = 32'h5A5A_5A5A;

  logic        hclk    = 1'b0;
  logic        hresetn = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = 32'h0;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        irq;
  logic [31:0] rd;
  logic [31:0] res;
  logic [31:0] st;
  logic [31:0] a;
  logic [31:0] b;
  logic        l1;
  logic        l2;
  logic        m;
  logic        f;
  add_op_t     op;
  int          num_errors  = 0;
  int          check_count = 0;
  int          cycles      = 0;

  add_unit dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq)
  );

  always #25 hclk = ~hclk;

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      num_errors++;
      give_verdict();
    end
  end

  // ****************************
  // Bus master and comparison
  // ****************************
  // Upper address bits are random: the block decodes only the low twelve
  task automatic bus(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    haddr  <= {20'($urandom), ad};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] cmd(input add_op_t o, input logic [1:0] lit,
                                      input logic [4:0] s1, input logic [4:0] s2,
                                      input logic [4:0] d);
    cmd = 32'h0;
    cmd[1:0] = o;
    cmd[CMD_LIT2_BIT -: 2] = lit;
    cmd[CMD_S1_LSB +: 5] = s1;
    cmd[CMD_S2_LSB +: 5] = s2;
    cmd[CMD_DST_LSB +: 5] = d;
  endfunction

  function automatic logic ovf(input logic [31:0] x, input logic [31:0] y);
    logic [31:0] s;
    s = y + x;
    ovf = (x[31] == y[31]) && (s[31] != x[31]);
  endfunction

  // Destination is preset to KEEP so a suppressed write shows up
  task automatic run(input logic [31:0] actl, input logic [31:0] x,
                     input logic [31:0] y, input logic [31:0] c);
    bus(1'b1, ACTL_OFS, actl);
    bus(1'b1, 12'h004, x);
    bus(1'b1, 12'h008, y);
    bus(1'b1, 12'h00C, KEEP);
    bus(1'b1, ICLR_OFS, 32'h7F);
    bus(1'b1, CMD_OFS, c);
    bus(1'b0, 12'h00C, 32'h0);
    res = rd;
    bus(1'b0, IST_OFS, 32'h0);
    st = rd;
  endtask

  task automatic rcase(input logic [31:0] actl, input logic [31:0] x, input logic [31:0] y,
                       input logic [31:0] er, input logic [31:0] es);
    run(actl, x, y, cmd(OP_ADDR, 2'h0, 5'h1, 5'h2, 5'h3));
    chk(res, er);
    chk(st, es);
  endtask

  task automatic give_verdict();
    $display("errors %0d, checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ****************************
  // Main sequence
  // ****************************
  initial begin
    void'($urandom(32'hF36BA9E1));
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, ACTL_OFS, 32'h0);
    chk(rd, ACTL_RESET);
    bus(1'b0, IST_OFS, 32'h0);
    chk(rd, 32'h0);
    a = $urandom;
    bus(1'b1, 12'h028, a);
    bus(1'b0, 12'h028, 32'h0);
    chk(rd, a);
    bus(1'b1, 12'h0A0, a);
    bus(1'b0, 12'h0A0, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 40; i++) begin
      a = $urandom;
      b = $urandom;
      op = add_op_t'(2'($urandom_range(1, 0)));
      m = 1'($urandom_range(1, 0));
      l1 = ($urandom_range(7, 0) == 0);
      l2 = ($urandom_range(7, 0) == 0);
      if (i < 3) begin
        a = (i == 2) ? 32'hFFFF_FFFF : {i[0], {31{~i[0]}}};
        b = (i == 1) ? a : 32'h1;
        op = (i == 2) ? OP_ADDO : OP_ADDI;
        m = (i == 1);
        l1 = 1'b0;
        l2 = 1'b0;
      end
      run({31'h0, m}, a, b, cmd(op, {l2, l1}, 5'h1, 5'h2, 5'h3));
      a = l1 ? 32'h1 : a;
      b = l2 ? 32'h2 : b;
      f = (op == OP_ADDI) && !m && ovf(a, b);
      chk(res, f ? KEEP : b + a);
      chk(st, {30'h0, f, 1'b1});
    end
    rcase(32'h0, 32'h3F80_0000, 32'h3F80_0000, 32'h4000_0000, 32'h1);
    rcase(32'h0, 32'h3F80_0000, 32'hBF80_0000, 32'h0000_0000, 32'h1);
    rcase(32'h20, 32'h3F80_0000, 32'hBF80_0000, 32'h8000_0000, 32'h1);
    rcase(32'h20, 32'h0000_0000, 32'h8000_0000, 32'h8000_0000, 32'h1);
    rcase(32'h0, 32'h8000_0000, 32'h8000_0000, 32'h8000_0000, 32'h1);
    rcase(32'h0, 32'h7F80_0000, 32'hFF80_0000, KEEP, 32'h11);
    rcase(32'h0, 32'h7FC0_0001, 32'h3F80_0000, 32'h7FC0_0001, 32'h1);
    rcase(32'h0, 32'hFF80_0000, 32'h3F80_0000, 32'hFF80_0000, 32'h1);
    rcase(32'h0, 32'h0000_0000, 32'hC040_0000, 32'hC040_0000, 32'h1);
    rcase(32'h0, 32'h8080_0001, 32'h0080_0000, 32'h8000_0000, 32'h29);
    rcase(32'h0, 32'h7F80_0001, 32'h3F80_0000, KEEP, 32'h11);
    rcase(32'h4, 32'h0000_0001, 32'h3F80_0000, KEEP, 32'h41);
    rcase(32'h0, 32'h3080_0000, 32'h3F80_0000, 32'h3F80_0000, 32'h21);
    rcase(32'h2, 32'h3080_0000, 32'h3F80_0000, 32'h3F80_0000, 32'h1);
    bus(1'b1, 12'h010, 32'h0);
    bus(1'b1, 12'h014, 32'h3FF0_0000);
    bus(1'b1, 12'h018, 32'h0);
    bus(1'b1, 12'h01C, 32'h4000_0000);
    run(32'h0, 32'h0, 32'h0, cmd(OP_ADDRL, 2'h0, 5'h4, 5'h6, 5'h8));
    bus(1'b0, 12'h020, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 12'h024, 32'h0);
    chk(rd, 32'h4008_0000);
    bus(1'b1, IEN_OFS, 32'h1);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, ICLR_OFS, 32'h1);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, IEN_OFS, 32'h0);
    run(32'h0, 32'h1, 32'h2, cmd(OP_ADDO, 2'h0, 5'h1, 5'h2, 5'h3));
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, IEN_OFS, 32'h1);
    bus(1'b0, IEN_OFS, 32'h0);
    chk(rd, 32'h1);
    chk({31'h0, irq}, 32'h1);
    give_verdict();
  end
endmodule // add_unit_tb

bind add_unit add_unit_sva chk_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq)
);
